// ==== rtl/emp_pkg.sv ====
// Constants and types for the external memory page control block
package emp_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [15:0] IDX_PAGE1 = 16'hc018;
  localparam logic [15:0] IDX_PAGE2 = 16'hc01a;
  localparam logic [15:0] IDX_UPEN = 16'hc038;
  localparam logic [15:0] IDX_CTRL = 16'hc03a;
  // Reset values
  localparam logic [15:0] PAGE_RST = 16'h0000;
  localparam logic UPEN_RST = 1'b0;
  localparam logic [13:0] CTRL_RST = 14'h0000;
  // Field positions and widths
  localparam int UPEN_BIT = 3;
  localparam int RAM_MERGE_BIT = 13;
  localparam int ROM_MERGE_BIT = 12;
  localparam int PMEM_WIDTH_BIT = 11;
  localparam int PMEM_WAIT_LSB = 8;
  localparam int ROM_WIDTH_BIT = 7;
  localparam int ROM_WAIT_LSB = 4;
  localparam int RAM_WIDTH_BIT = 3;
  localparam int RAM_WAIT_LSB = 0;
  localparam int WAIT_W = 3;
  localparam int CTRL_W = 14;
  localparam int PIN_FULL_W = 9;
  localparam int PIN_SRAM_W = 5;
  localparam int UPPER_W = 4;
  // Paged window
  localparam logic [15:0] WIN_LO = 16'h8000;
  localparam logic [15:0] WIN_HI = 16'h9fff;
  // Wait-state clock derived from the system clock
  localparam int SYS_MHZ = 100;
  localparam int WAIT_MHZ = 48;
  localparam logic [6:0] SYS_MHZ_V = 7'(SYS_MHZ);
  localparam logic [6:0] WAIT_MHZ_V = 7'(WAIT_MHZ);
  // Bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] UPPER_IDLE = 4'hf;
  typedef enum logic [1:0] {SP_RAM, SP_ROM, SP_PAGE} emp_space_t;
  typedef enum logic {ST_IDLE, ST_ACTIVE} emp_fsm_t;
endpackage

// ==== rtl/emp_ctrl.sv ====
// External memory page control: registers, chip selects, wait states
`timescale 1ns/1ps
`default_nettype none
// Function
// (R1) Page register appended to paged window accesses
// (R2) Page register holds page address 28..13
// (R3) Window 0x8000-0x9FFF drives pins [8:0]
// (R4) SRAM mode drives only pins [4:0]
// (R5) Software clears bit 8; paged select asserted
// (R6) Upper enable gives A[18:15] to addressing
// (R7) Upper enable resets to disabled
// (R8) A[18:15] driven high from power up
// (R9) Wait states counted in 48 MHz periods
// (R10) RAM merge adds RAM select to paged
// (R11) ROM merge adds ROM select to paged
// (R12) Bit 11 sets paged memory width
// (R13) Bits 10:8 set paged memory waits
// (R14) Bit 7 sets ROM width
// (R15) Bits 6:4 set ROM waits
// (R16) Bit 3 sets RAM width
// (R17) Bits 2:0 set RAM waits
// (R18) Software writes zero to reserved bits
// (R19) Each wait lengthens strobe one 48 MHz period
module emp_ctrl #(
  parameter int ADDR_W = 20
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Processor access request
  input wire logic cpu_req,
  input wire logic [15:0] cpu_addr,
  input wire emp_pkg::emp_space_t cpu_space,
  input wire logic cpu_page2,
  input wire logic cpu_we,
  input wire logic [3:0] cpu_upper_addr,
  input wire logic sram_mode,
  output logic cpu_ack,
  // External memory pins
  output logic ext_mem_chip_select_n,
  output logic ext_ram_chip_select_n,
  output logic ext_rom_chip_select_n,
  output logic ext_rd_strobe_n,
  output logic ext_wr_strobe_n,
  output logic ext_width8,
  output logic [8:0] ext_page_pins,
  output logic [3:0] ext_upper_addr
);

  if (ADDR_W < 18 || ADDR_W > 32) begin : g_addr_w_check
    $error("emp_ctrl: ADDR_W must lie in 18..32");
  end

  typedef struct packed {
    logic [15:0] page1;
    logic [15:0] page2;
    logic upen;
    logic [13:0] ctrl;
    logic aw_got;
    logic [ADDR_W-1:0] awaddr;
    logic w_got;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [15:0] rdata;
    emp_pkg::emp_fsm_t st;
    logic [2:0] wait_left;
    logic [6:0] phase;
    logic cs_mem;
    logic cs_ram;
    logic cs_rom;
    logic we;
    logic width8;
    logic [8:0] pins;
    logic [3:0] upper;
    logic ack;
  } emp_state_t;

  emp_state_t s_q, s_d;

  // Returns register number 0..3, or 4 when unmapped
  function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
    reg_sel = 3'h4;
    if (a[1:0] != 2'h0) begin
      reg_sel = 3'h4;
    end else if (a[ADDR_W-1:2] == (ADDR_W-2)'(emp_pkg::IDX_PAGE1)) begin
      reg_sel = 3'h0;
    end else if (a[ADDR_W-1:2] == (ADDR_W-2)'(emp_pkg::IDX_PAGE2)) begin
      reg_sel = 3'h1;
    end else if (a[ADDR_W-1:2] == (ADDR_W-2)'(emp_pkg::IDX_UPEN)) begin
      reg_sel = 3'h2;
    end else if (a[ADDR_W-1:2] == (ADDR_W-2)'(emp_pkg::IDX_CTRL)) begin
      reg_sel = 3'h3;
    end
  endfunction

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] lane(input logic [15:0] old,
                                       input logic [15:0] nw,
                                       input logic [1:0] st);
    lane = {st[1] ? nw[15:8] : old[15:8], st[0] ? nw[7:0] : old[7:0]};
  endfunction

  logic [2:0] wsel;
  logic [2:0] rsel;
  logic tick;
  logic [7:0] phase_sum;
  logic in_win;
  logic [15:0] page_sel;
  logic [15:0] ctrl_new;
  logic [2:0] wait_sel;
  logic width_sel;

  always_comb begin
    s_d = s_q;
    wsel = reg_sel(s_q.awaddr);
    rsel = reg_sel(s_axi_araddr);
    ctrl_new = 16'h0000;
    // (R9) 48 MHz tick from the system clock
    phase_sum = {1'b0, s_q.phase} + {1'b0, emp_pkg::WAIT_MHZ_V};
    tick = phase_sum >= {1'b0, emp_pkg::SYS_MHZ_V};
    in_win = cpu_addr >= emp_pkg::WIN_LO && cpu_addr <= emp_pkg::WIN_HI;
    page_sel = cpu_page2 ? s_q.page2 : s_q.page1;
    // (R17) RAM wait field by default
    wait_sel = s_q.ctrl[emp_pkg::RAM_WAIT_LSB +: emp_pkg::WAIT_W];
    // (R16) RAM width bit by default
    width_sel = s_q.ctrl[emp_pkg::RAM_WIDTH_BIT];
    // (R13) Paged memory wait field
    // (R12) Paged memory width bit
    if (cpu_space == emp_pkg::SP_PAGE) begin
      wait_sel = s_q.ctrl[emp_pkg::PMEM_WAIT_LSB +: emp_pkg::WAIT_W];
      width_sel = s_q.ctrl[emp_pkg::PMEM_WIDTH_BIT];
    // (R15) ROM wait field
    // (R14) ROM width bit
    end else if (cpu_space == emp_pkg::SP_ROM) begin
      wait_sel = s_q.ctrl[emp_pkg::ROM_WAIT_LSB +: emp_pkg::WAIT_W];
      width_sel = s_q.ctrl[emp_pkg::ROM_WIDTH_BIT];
    end
    if (ce) begin
      s_d.phase = tick ? 7'(phase_sum - {1'b0, emp_pkg::SYS_MHZ_V})
                       : phase_sum[6:0];
      // Write address and data, taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
        s_d.aw_got = 1'b1;
        s_d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_d.w_got = 1'b1;
        s_d.wdata = s_axi_wdata[15:0];
        s_d.wstrb = s_axi_wstrb[1:0];
      end
      if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
        s_d.aw_got = 1'b0;
        s_d.w_got = 1'b0;
        s_d.bvalid = 1'b1;
        s_d.bresp = emp_pkg::RESP_OKAY;
        ctrl_new = lane({2'b00, s_q.ctrl}, s_q.wdata, s_q.wstrb);
        // (R2) Full 16-bit page fields, bits 28..13
        if (wsel == 3'h0) begin
          s_d.page1 = lane(s_q.page1, s_q.wdata, s_q.wstrb);
        end else if (wsel == 3'h1) begin
          s_d.page2 = lane(s_q.page2, s_q.wdata, s_q.wstrb);
        end else if (wsel == 3'h2) begin
          if (s_q.wstrb[0]) begin
            s_d.upen = s_q.wdata[emp_pkg::UPEN_BIT];
          end
        end else if (wsel == 3'h3) begin
          s_d.ctrl = ctrl_new[emp_pkg::CTRL_W-1:0];
        end else begin
          s_d.bresp = emp_pkg::RESP_SLVERR;
        end
      end
      if (s_q.bvalid && s_axi_bready) begin
        s_d.bvalid = 1'b0;
      end
      // Read: one cycle to the answer
      if (s_axi_arvalid && s_axi_arready) begin
        s_d.rvalid = 1'b1;
        s_d.rresp = emp_pkg::RESP_OKAY;
        s_d.rdata = 16'h0000;
        if (rsel == 3'h0) begin
          s_d.rdata = s_q.page1;
        end else if (rsel == 3'h1) begin
          s_d.rdata = s_q.page2;
        end else if (rsel == 3'h2) begin
          s_d.rdata[emp_pkg::UPEN_BIT] = s_q.upen;
        end else if (rsel == 3'h3) begin
          s_d.rdata = {2'b00, s_q.ctrl};
        end else begin
          s_d.rresp = emp_pkg::RESP_SLVERR;
        end
      end else if (s_q.rvalid && s_axi_rready) begin
        s_d.rvalid = 1'b0;
      end
      // (R6) Upper pins follow the processor only when enabled
      // (R8) Otherwise held high
      s_d.upper = s_q.upen ? cpu_upper_addr : emp_pkg::UPPER_IDLE;
      s_d.ack = 1'b0;
      case (s_q.st)
        emp_pkg::ST_IDLE: begin
          if (cpu_req) begin
            s_d.st = emp_pkg::ST_ACTIVE;
            s_d.wait_left = wait_sel;
            s_d.width8 = width_sel;
            s_d.we = cpu_we;
            s_d.cs_mem = cpu_space == emp_pkg::SP_PAGE;
            // (R10) RAM select merged onto paged select
            s_d.cs_ram = cpu_space == emp_pkg::SP_RAM ||
              (cpu_space == emp_pkg::SP_PAGE &&
               s_q.ctrl[emp_pkg::RAM_MERGE_BIT]);
            // (R11) ROM select merged onto paged select
            s_d.cs_rom = cpu_space == emp_pkg::SP_ROM ||
              (cpu_space == emp_pkg::SP_PAGE &&
               s_q.ctrl[emp_pkg::ROM_MERGE_BIT]);
            s_d.pins = '0;
            // (R1) Page bits appended in the window
            // (R3) Pins [8:0] carry page bits 21..13
            // (R4) SRAM mode keeps only pins [4:0]
            if (cpu_space == emp_pkg::SP_PAGE && in_win) begin
              s_d.pins = sram_mode ?
                {4'h0, page_sel[emp_pkg::PIN_SRAM_W-1:0]} :
                page_sel[emp_pkg::PIN_FULL_W-1:0];
            end
          end
        end
        emp_pkg::ST_ACTIVE: begin
          // (R19) One extra 48 MHz period per wait state
          if (tick) begin
            if (s_q.wait_left == 3'h0) begin
              s_d.st = emp_pkg::ST_IDLE;
              s_d.cs_mem = 1'b0;
              s_d.cs_ram = 1'b0;
              s_d.cs_rom = 1'b0;
              s_d.ack = 1'b1;
            end else begin
              s_d.wait_left = s_q.wait_left - 3'h1;
            end
          end
        end
        default: begin
          s_d.st = emp_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.page1 <= emp_pkg::PAGE_RST;
      s_q.page2 <= emp_pkg::PAGE_RST;
      // (R7) Upper enable disabled after reset
      s_q.upen <= emp_pkg::UPEN_RST;
      s_q.ctrl <= emp_pkg::CTRL_RST;
      s_q.st <= emp_pkg::ST_IDLE;
      s_q.upper <= emp_pkg::UPPER_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
  assign s_axi_wready = !s_q.w_got && !s_q.bvalid;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rresp = s_q.rresp;
  assign s_axi_rdata = {16'h0000, s_q.rdata};
  assign cpu_ack = s_q.ack;
  assign ext_mem_chip_select_n = !s_q.cs_mem;
  assign ext_ram_chip_select_n = !s_q.cs_ram;
  assign ext_rom_chip_select_n = !s_q.cs_rom;
  assign ext_rd_strobe_n = !(s_q.st == emp_pkg::ST_ACTIVE && !s_q.we);
  assign ext_wr_strobe_n = !(s_q.st == emp_pkg::ST_ACTIVE && s_q.we);
  assign ext_width8 = s_q.width8;
  assign ext_page_pins = s_q.pins;
  assign ext_upper_addr = s_q.upper;

  // Strobe length and programmed waits, kept for the checks
  logic [5:0] strobe_len;
  logic [2:0] wait_seen;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe_len <= 6'h00;
      wait_seen <= 3'h0;
    end else if (ce) begin
      strobe_len <= s_q.st == emp_pkg::ST_IDLE ? 6'h00 : strobe_len + 6'h01;
      if (s_q.st == emp_pkg::ST_IDLE && cpu_req) begin
        wait_seen <= wait_sel;
      end
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_merge_ram: assert property (!ext_mem_chip_select_n && // R10
    s_q.ctrl[emp_pkg::RAM_MERGE_BIT] && $stable(s_q.ctrl)
    |-> !ext_ram_chip_select_n)
    else $error("RAM select not merged");
  a_merge_rom: assert property (!ext_mem_chip_select_n && // R11
    s_q.ctrl[emp_pkg::ROM_MERGE_BIT] && $stable(s_q.ctrl)
    |-> !ext_rom_chip_select_n)
    else $error("ROM select not merged");
  a_upper_idle: assert property (!s_q.upen && ce // R6
    |=> ext_upper_addr == emp_pkg::UPPER_IDLE)
    else $error("Upper pins not high while disabled");
  a_upper_reset: assert property ($rose(aresetn) // R7
    |-> !s_q.upen && ext_upper_addr == emp_pkg::UPPER_IDLE)
    else $error("Upper enable not cleared by reset");
  a_sram_pins: assert property (s_q.st == emp_pkg::ST_IDLE && cpu_req // R4
    && ce && sram_mode |=> ext_page_pins[8:5] == 4'h0)
    else $error("SRAM mode drove high page pins");
  a_page_pins: assert property (s_q.st == emp_pkg::ST_IDLE && cpu_req // R3
    && ce && !sram_mode && cpu_space == emp_pkg::SP_PAGE && in_win
    && !cpu_page2 |=> ext_page_pins == $past(s_q.page1[8:0]))
    else $error("Page pins do not show page register");
  a_zero_wait: assert property (s_q.st == emp_pkg::ST_IDLE && cpu_req // R19
    && ce && wait_sel == 3'h0 |=> ##[1:3] cpu_ack)
    else $error("Zero-wait access too long");
  a_max_wait: assert property (!ext_rd_strobe_n || // R13
    !ext_wr_strobe_n |-> strobe_len <= 6'd20)
    else $error("Strobe ran beyond eight wait periods");
  a_strobe_min: assert property (cpu_ack |-> // R9
    $past(strobe_len) >= {2'b00, wait_seen, 1'b0})
    else $error("Strobe shorter than programmed waits");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("Write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("Read answer dropped");
  a_ack_pulse: assert property (cpu_ack && ce |=> !cpu_ack) // R19
    else $error("Access acknowledge longer than one cycle");
  a_idle_selects: assert property (ext_rd_strobe_n && ext_wr_strobe_n
    |-> ext_mem_chip_select_n && ext_ram_chip_select_n &&
    ext_rom_chip_select_n)
    else $error("Chip select active outside an access");

  c_paged: cover property (!ext_mem_chip_select_n &&
    !ext_ram_chip_select_n);
  c_wait7: cover property (cpu_ack && strobe_len > 6'd14);
  c_unmapped: cover property (s_axi_rvalid &&
    s_axi_rresp == emp_pkg::RESP_SLVERR);
  c_rom_merge: cover property (!ext_mem_chip_select_n &&
    !ext_rom_chip_select_n);
  c_upper_on: cover property (s_q.upen &&
    ext_upper_addr != emp_pkg::UPPER_IDLE);

endmodule
`default_nettype wire

// ==== test/emp_mem_model.sv ====
// Observer model of the external memory on the far side
`timescale 1ns/1ps
`default_nettype none
module emp_mem_model (
  // Clock
  input wire logic aclk,
  // Memory pins
  input wire logic mem_cs_n,
  input wire logic ram_cs_n,
  input wire logic rom_cs_n,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic width8,
  input wire logic [8:0] pins,
  input wire logic [3:0] upper,
  // Last access as the memory saw it
  output logic [7:0] scyc,
  output logic [2:0] ssel,
  output logic [8:0] spins,
  output logic sw8,
  output logic [3:0] sup,
  output logic swr
);
  logic act_q;
  initial begin
    act_q = 1'b0;
    scyc = 8'h00;
  end
  // Strobe length counted in system clock edges
  always @(posedge aclk) begin
    if (!rd_n || !wr_n) begin
      scyc <= act_q ? scyc + 8'h01 : 8'h01;
      ssel <= {!mem_cs_n, !ram_cs_n, !rom_cs_n};
      spins <= pins;
      sw8 <= width8;
      sup <= upper;
      swr <= !wr_n;
    end
    act_q <= !rd_n || !wr_n;
  end
endmodule
`default_nettype wire

// ==== test/tb_external_memory_page_control.sv ====
// Register and access tests for the page control block
`timescale 1ns/1ps
`default_nettype none
module tb_external_memory_page_control;
  logic aclk, aresetn, awv, awr, wv, wr_rdy, bv, br, arv, arr, rv, rr;
  logic ce, swr, ok;
  logic [19:0] awa, ara;
  logic [31:0] wd, rdat, d;
  logic [1:0] bresp, rresp, r;
  logic req, pg2, we, sm, ack, mcs, rcs, ocs, rdn, wrn, w8, sw8, ew;
  logic [15:0] ca, c, pv;
  logic [8:0] pins, spins;
  logic [3:0] up, sup;
  logic [7:0] scyc;
  logic [2:0] ssel, es;
  emp_pkg::emp_space_t spc;
  emp_pkg::emp_space_t sp[7];
  logic [15:0] ct[7];
  logic [1:0] fl[7];
  int wt, n8;
  int error_cnt = 0;
  int cmp_count = 0;

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  emp_ctrl #(.ADDR_W(20)) dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'h3), .s_axi_wvalid(wv),
    .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .cpu_req(req), .cpu_addr(ca),
    .cpu_space(spc), .cpu_page2(pg2), .cpu_we(we), .cpu_upper_addr(4'h5),
    .sram_mode(sm), .cpu_ack(ack), .ext_mem_chip_select_n(mcs),
    .ext_ram_chip_select_n(rcs), .ext_rom_chip_select_n(ocs),
    .ext_rd_strobe_n(rdn), .ext_wr_strobe_n(wrn), .ext_width8(w8),
    .ext_page_pins(pins), .ext_upper_addr(up));

  emp_mem_model mem (.aclk(aclk), .mem_cs_n(mcs), .ram_cs_n(rcs),
    .rom_cs_n(ocs), .rd_n(rdn), .wr_n(wrn), .width8(w8), .pins(pins),
    .upper(up), .scyc(scyc), .ssel(ssel), .spins(spins), .sw8(sw8),
    .sup(sup), .swr(swr));

  task automatic stop_test();
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic hang();
    error_cnt++;
    $display("unexpected at %0t: wait timed out", $time);
    stop_test();
  endtask

  function automatic logic [19:0] ba(input logic [15:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction

  task automatic wr(input logic [19:0] a, input logic [15:0] v);
    @(posedge aclk);
    awa <= a;
    awv <= 1'b1;
    wd <= {16'h0000, v};
    wv <= 1'b1;
    br <= 1'b1;
    for (int n = 0; n <= 40; n++) begin
      if (n == 40) hang();
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
      if (bv) begin
        r = bresp;
        br <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [19:0] a);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    for (int n = 0; n <= 40; n++) begin
      if (n == 40) hang();
      @(posedge aclk);
      if (arr) arv <= 1'b0;
      if (rv) begin
        d = rdat;
        r = rresp;
        rr <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rchk(input logic [15:0] idx, input logic [15:0] v);
    rd(ba(idx));
    chk({r, d}, {emp_pkg::RESP_OKAY, 16'h0000, v});
  endtask

  task automatic go(input int i);
    @(posedge aclk);
    spc <= sp[i];
    ca <= sp[i] == emp_pkg::SP_PAGE ? 16'h9fff : 16'h0100;
    pg2 <= fl[i][1];
    sm <= fl[i][0];
    we <= i[0];
    req <= 1'b1;
    @(posedge aclk);
    req <= 1'b0;
    for (int n = 0; n <= 60; n++) begin
      if (n == 60) hang();
      @(posedge aclk);
      if (ack) break;
    end
    @(posedge aclk);
  endtask

  initial begin
    {aresetn, awv, wv, br, arv, rr, req, pg2, we, sm} = 10'h000;
    {awa, ara, wd, ca} = 88'h0;
    spc = emp_pkg::SP_RAM;
    ce = 1'b1;
    sp = '{emp_pkg::SP_RAM, emp_pkg::SP_RAM, emp_pkg::SP_ROM,
      emp_pkg::SP_PAGE, emp_pkg::SP_PAGE, emp_pkg::SP_PAGE, emp_pkg::SP_ROM};
    ct = '{16'h000f, 16'h0000, 16'h00f0, 16'h3f00, 16'h0000, 16'h2000,
      16'h1000};
    fl = '{2'b00, 2'b00, 2'b00, 2'b00, 2'b11, 2'b10, 2'b00};
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    chk(up, 4'hf);
    rchk(emp_pkg::IDX_PAGE1, 16'h0000);
    rchk(emp_pkg::IDX_UPEN, 16'h0000);
    rd(20'h00010);
    chk({r, d}, {emp_pkg::RESP_SLVERR, 32'h0});
    wr(20'h30061, 16'h0001);
    chk(r, emp_pkg::RESP_SLVERR);
    wr(ba(emp_pkg::IDX_PAGE1), 16'h12ab);
    wr(ba(emp_pkg::IDX_PAGE2), 16'h0e55);
    rchk(emp_pkg::IDX_PAGE1, 16'h12ab);
    rchk(emp_pkg::IDX_PAGE2, 16'h0e55);
    for (int i = 0; i < 7; i++) begin
      if (i == 3) begin
        wr(ba(emp_pkg::IDX_UPEN), 16'h0008);
        rchk(emp_pkg::IDX_UPEN, 16'h0008);
      end
      wr(ba(emp_pkg::IDX_CTRL), ct[i]);
      rchk(emp_pkg::IDX_CTRL, ct[i]);
      go(i);
      c = ct[i];
      case (sp[i])
        emp_pkg::SP_RAM: begin
          wt = c[2:0];
          ew = c[3];
          es = 3'b010;
        end
        emp_pkg::SP_ROM: begin
          wt = c[6:4];
          ew = c[7];
          es = 3'b001;
        end
        default: begin
          wt = c[10:8];
          ew = c[11];
          es = {1'b1, c[13:12]};
        end
      endcase
      n8 = 100 * (wt + 1);
      chk(sw8, ew);
      chk(swr, i[0]);
      chk(ssel, es);
      chk(sup, i >= 3 ? 4'h5 : 4'hf);
      ok = scyc >= n8 / 48 - 1 && scyc <= (n8 + 99) / 48;
      chk(ok, 1'b1);
      if (sp[i] == emp_pkg::SP_PAGE) begin
        pv = fl[i][1] ? 16'h0e55 : 16'h12ab;
        chk(spins, fl[i][0] ? {4'h0, pv[4:0]} : pv[8:0]);
      end
    end
    wr(ba(emp_pkg::IDX_UPEN), 16'h0000);
    rchk(emp_pkg::IDX_UPEN, 16'h0000);
    chk(up, 4'hf);
    // Clock enable low: a held request must not start an access
    @(posedge aclk);
    ce <= 1'b0;
    spc <= emp_pkg::SP_PAGE;
    req <= 1'b1;
    repeat (4) @(posedge aclk);
    chk({mcs, rdn, wrn, ack}, 4'he);
    ce <= 1'b1;
    req <= 1'b0;
    @(posedge aclk);
    stop_test();
  end
endmodule
`default_nettype wire
